// File: rtl/line_addressed_set_selector.sv
// Line-addressed parameter set selector with AHB-Lite register slave
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module line_addressed_set_selector #(
	parameter int PARAM_W = 32
) (
	// Clock, reset and enable
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Input lines and frame timing
	input wire logic [1:0] line_in,
	input wire logic frame_trig,
	input wire logic frame_end,
	// Camera side results
	output logic [PARAM_W-1:0] active_params,
	output logic [1:0] set_in_use,
	output logic waiting_trig,
	output logic frame_busy,
	output logic seq_running
);

	// Bus state
	logic hreadyout_reg;
	logic [31:0] hrdata_reg;
	logic dp_wr_reg;
	logic rd_pend_reg;
	logic [7:0] dp_addr_reg;
	logic acc;
	logic [31:0] rd_mux;

	// Configuration
	logic sequencer_on;
	logic [1:0] set_advance_policy;
	logic [2:0] set_count;
	logic addr_bit_pick;
	logic [1:0] addr_bit_line;
	logic [1:0] invert_reg;
	logic [1:0] slot_pick;
	logic save_active_to_slot;

	// Parameter storage
	logic [PARAM_W-1:0] slots_reg [set_sel_pkg::SLOT_MAX];
	logic [PARAM_W-1:0] active_reg;
	logic [PARAM_W-1:0] saved_reg;
	logic [1:0] cur_set_reg;

	// Line synchroniser
	logic [1:0] ls1_reg;
	logic [1:0] ls2_reg;
	logic [1:0] ls3_reg;
	logic [1:0] line_st_reg;
	logic moving;

	// Frame and sequencer state
	logic busy_reg;
	logic live_reg;
	logic waiting_reg;
	logic waiting_c;
	logic trig_ok;
	logic use_seq;
	logic b0;
	logic b1;
	logic [1:0] dec_addr;
	logic addr_ok;
	logic seq_start;
	logic seq_stop;

	function automatic logic line_val(input logic [1:0] lv,
		input logic src, input logic [1:0] inv);
		line_val = lv[src] ^ inv[src];
	endfunction

	function automatic logic [2:0] clamp_count(input logic [31:0] v);
		if (v > 32'(set_sel_pkg::COUNT_MAX)) begin
			clamp_count = set_sel_pkg::COUNT_MAX;
		end else if (v < 32'(set_sel_pkg::COUNT_MIN)) begin
			clamp_count = set_sel_pkg::COUNT_MIN;
		end else begin
			clamp_count = v[2:0];
		end
	endfunction

	function automatic logic wr_go(input logic wr, input logic [7:0] a,
		input logic [7:0] off);
		wr_go = wr && (a == off);
	endfunction

	assign acc = hsel && htrans[1] && hready;

	// Reads take one wait state so a write just before is already seen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			dp_addr_reg <= 8'h00;
			hreadyout_reg <= 1'b1;
			hrdata_reg <= 32'h0000_0000;
		end else if (ce) begin
			dp_wr_reg <= acc && hwrite && (hsize == set_sel_pkg::HSIZE_WORD);
			rd_pend_reg <= acc && !hwrite;
			hreadyout_reg <= !(acc && !hwrite);
			if (acc) begin
				dp_addr_reg <= haddr[7:0];
			end
			if (rd_pend_reg) begin
				hrdata_reg <= rd_mux;
			end
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (dp_addr_reg)
			set_sel_pkg::OFF_CTRL: begin
				rd_mux[set_sel_pkg::CTRL_ON_BIT] = sequencer_on;
				rd_mux[set_sel_pkg::CTRL_POL_LSB +: 2] = set_advance_policy;
			end
			set_sel_pkg::OFF_COUNT: rd_mux[2:0] = set_count;
			set_sel_pkg::OFF_PICK: rd_mux[0] = addr_bit_pick;
			set_sel_pkg::OFF_LINE: rd_mux[0] = addr_bit_line[addr_bit_pick];
			set_sel_pkg::OFF_SLOT: rd_mux[1:0] = slot_pick;
			set_sel_pkg::OFF_ACTIVE: rd_mux = 32'(active_reg);
			set_sel_pkg::OFF_INVERT: rd_mux[1:0] = invert_reg;
			set_sel_pkg::OFF_STATUS: begin
				rd_mux[set_sel_pkg::ST_SET_LSB +: 2] = cur_set_reg;
				rd_mux[set_sel_pkg::ST_WAIT_BIT] = waiting_reg;
				rd_mux[set_sel_pkg::ST_BUSY_BIT] = busy_reg;
				rd_mux[set_sel_pkg::ST_RUN_BIT] = live_reg;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Configuration writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sequencer_on <= 1'b0;
			set_advance_policy <= set_sel_pkg::POLICY_OTHER;
			set_count <= set_sel_pkg::COUNT_RST;
			addr_bit_pick <= 1'b0;
			addr_bit_line <= set_sel_pkg::SRC_RST;
			invert_reg <= set_sel_pkg::INV_RST;
			slot_pick <= 2'h0;
		end else if (ce) begin
			if (wr_go(dp_wr_reg, dp_addr_reg, set_sel_pkg::OFF_CTRL)) begin
				sequencer_on <= hwdata[set_sel_pkg::CTRL_ON_BIT];
				set_advance_policy <= hwdata[set_sel_pkg::CTRL_POL_LSB +: 2];
			end
			if (wr_go(dp_wr_reg, dp_addr_reg, set_sel_pkg::OFF_COUNT)) begin
				set_count <= clamp_count(hwdata);
				if (clamp_count(hwdata) <= set_sel_pkg::COUNT_TWO) begin
					addr_bit_pick <= 1'b0;
				end
			end else if (wr_go(dp_wr_reg, dp_addr_reg,
				set_sel_pkg::OFF_PICK)) begin
				// Only bit 0 exists while two sets or fewer are in use
				addr_bit_pick <= (set_count > set_sel_pkg::COUNT_TWO) ?
					hwdata[0] : 1'b0;
			end
			if (wr_go(dp_wr_reg, dp_addr_reg, set_sel_pkg::OFF_LINE)) begin
				addr_bit_line[addr_bit_pick] <= hwdata[0];
			end
			if (wr_go(dp_wr_reg, dp_addr_reg, set_sel_pkg::OFF_INVERT)) begin
				invert_reg <= hwdata[1:0];
			end
			if (wr_go(dp_wr_reg, dp_addr_reg, set_sel_pkg::OFF_SLOT)) begin
				slot_pick <= hwdata[1:0];
			end
		end
	end

	assign save_active_to_slot =
		wr_go(dp_wr_reg, dp_addr_reg, set_sel_pkg::OFF_STORE);

	// Three-stage synchroniser; a change counts once stages two and three agree
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ls1_reg <= 2'h0;
			ls2_reg <= 2'h0;
			ls3_reg <= 2'h0;
			line_st_reg <= 2'h0;
		end else if (ce) begin
			ls1_reg <= line_in;
			ls2_reg <= ls1_reg;
			ls3_reg <= ls2_reg;
			if (ls2_reg == ls3_reg) begin
				line_st_reg <= ls3_reg;
			end
		end
	end

	assign moving = (ls2_reg != ls3_reg) || (ls3_reg != line_st_reg);

	// Address decode; bit 1 only counts above two sets
	assign b0 = line_val(line_st_reg, addr_bit_line[0], invert_reg);
	assign b1 = (set_count > set_sel_pkg::COUNT_TWO) ?
		line_val(line_st_reg, addr_bit_line[1], invert_reg) : 1'b0;
	assign dec_addr = {b1, b0};
	// Addresses beyond the set count keep the current values
	assign addr_ok = {1'b0, dec_addr} < set_count;

	assign waiting_c = !busy_reg && !moving;
	assign trig_ok = frame_trig && waiting_c;
	assign use_seq = live_reg && sequencer_on &&
		(set_advance_policy == set_sel_pkg::LINE_DRIVEN_CHOICE);
	// Start and stop only between frames so no frame is cut short
	assign seq_start = !live_reg && sequencer_on && !busy_reg;
	assign seq_stop = live_reg && !sequencer_on && !busy_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_reg <= 1'b0;
			waiting_reg <= 1'b0;
		end else if (ce) begin
			waiting_reg <= waiting_c;
			if (trig_ok) begin
				busy_reg <= 1'b1;
			end else if (frame_end) begin
				busy_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			live_reg <= 1'b0;
			saved_reg <= '0;
		end else if (ce) begin
			if (seq_start) begin
				live_reg <= 1'b1;
				saved_reg <= active_reg;
			end else if (seq_stop) begin
				live_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			active_reg <= '0;
			cur_set_reg <= 2'h0;
		end else if (ce) begin
			if (seq_stop) begin
				active_reg <= saved_reg;
			end else if (trig_ok && use_seq && addr_ok) begin
				active_reg <= slots_reg[dec_addr];
				cur_set_reg <= dec_addr;
			end else if (wr_go(dp_wr_reg, dp_addr_reg,
				set_sel_pkg::OFF_ACTIVE)) begin
				active_reg <= hwdata[PARAM_W-1:0];
			end
		end
	end

	// Storage is not reset; software fills slots before use
	always_ff @(posedge hclk) begin
		if (ce && save_active_to_slot) begin
			slots_reg[slot_pick] <= active_reg;
		end
	end

	assign hreadyout = hreadyout_reg;
	assign hresp = set_sel_pkg::HRESP_OKAY;
	assign hrdata = hrdata_reg;
	assign active_params = active_reg;
	assign set_in_use = cur_set_reg;
	assign waiting_trig = waiting_reg;
	assign frame_busy = busy_reg;
	assign seq_running = live_reg;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_quiet_lines;
		(ce && $stable(line_in)) [*5];
	endsequence

	sequence s_read_wait;
		!hreadyout ##1 hreadyout;
	endsequence

	a_count_bound: assert property (
		set_count <= set_sel_pkg::COUNT_MAX && set_count >= 3'h1)
		else $error("set count out of range");

	a_trig_load: assert property (
		(ce && trig_ok && use_seq && addr_ok && !seq_stop) |=>
		(active_params == $past(slots_reg[dec_addr]) &&
		set_in_use == $past(dec_addr)))
		else $error("addressed set not loaded on trigger");

	a_trig_ignored: assert property (
		(ce && moving && frame_trig && !busy_reg) |=>
		(!frame_busy && !waiting_trig))
		else $error("trigger taken while line moving");

	a_store_copy: assert property (
		(ce && save_active_to_slot) |=>
		(slots_reg[$past(slot_pick)] == $past(active_reg)))
		else $error("store did not copy active values");

	a_restore_vals: assert property (
		(ce && seq_stop) |=> (active_params == $past(saved_reg) && !seq_running))
		else $error("values not restored on disable");

	a_hold_frame: assert property (
		(live_reg && busy_reg && !sequencer_on) |-> ##1 seq_running)
		else $error("sequencer stopped mid frame");

	a_two_bit0: assert property (
		(set_count <= set_sel_pkg::COUNT_TWO) |-> (dec_addr[1] == 1'b0 &&
		addr_bit_pick == 1'b0))
		else $error("bit 1 used with two sets");

	a_sync_line: assert property (
		s_quiet_lines |-> (line_st_reg == line_in && !moving))
		else $error("synchronised line lags a quiet input");

	a_read_ws: assert property (
		(ce && acc && !hwrite) ##1 ce |-> s_read_wait)
		else $error("read wait state wrong");

endmodule // line_addressed_set_selector

// File: shared/set_sel_pkg.sv
// Register map, fields, reset values and codes for the set selector
package set_sel_pkg;
	// Byte offsets on the register bus
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_COUNT = 8'h04;
	localparam logic [7:0] OFF_PICK = 8'h08;
	localparam logic [7:0] OFF_LINE = 8'h0c;
	localparam logic [7:0] OFF_SLOT = 8'h10;
	localparam logic [7:0] OFF_STORE = 8'h14;
	localparam logic [7:0] OFF_ACTIVE = 8'h18;
	localparam logic [7:0] OFF_INVERT = 8'h1c;
	localparam logic [7:0] OFF_STATUS = 8'h20;
	// Control fields
	localparam int CTRL_ON_BIT = 0;
	localparam int CTRL_POL_LSB = 1;
	// Status fields
	localparam int ST_SET_LSB = 0;
	localparam int ST_WAIT_BIT = 2;
	localparam int ST_BUSY_BIT = 3;
	localparam int ST_RUN_BIT = 4;
	// Advance policy codes
	localparam logic [1:0] POLICY_OTHER = 2'h0;
	localparam logic [1:0] LINE_DRIVEN_CHOICE = 2'h2;
	// Set count limits
	localparam logic [2:0] COUNT_MIN = 3'h1;
	localparam logic [2:0] COUNT_TWO = 3'h2;
	localparam logic [2:0] COUNT_MAX = 3'h4;
	localparam int SLOT_MAX = 4;
	// Line codes for an address bit source
	localparam logic LINE_ONE = 1'b0;
	localparam logic LINE_TWO = 1'b1;
	// Reset values
	localparam logic [2:0] COUNT_RST = 3'h2;
	localparam logic [1:0] SRC_RST = 2'h2;
	localparam logic [1:0] INV_RST = 2'h0;
	// Bus codes
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'b0;
endpackage

// File: verif/line_driver.sv
// Model of the equipment that drives the camera input lines
`timescale 1ns/10ps
module line_driver (
	// Clock
	input wire logic hclk,
	// Commanded and driven line levels
	input wire logic [1:0] want,
	output logic [1:0] line_in
);
	// Levels change only on command, then hold, so setup before a trigger
	// is always met unless the bench means to break it
	always_ff @(posedge hclk) begin
		line_in <= want;
	end
endmodule // line_driver

// File: verif/line_addressed_set_selector_test.sv
// Self-checking bench for the line-addressed set selector
`timescale 1ns/10ps
module line_addressed_set_selector_test;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic ce = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic frame_trig = 1'b0;
	logic frame_end = 1'b0;
	logic [1:0] want = 2'h0;
	logic hreadyout, hresp, waiting_trig, frame_busy, seq_running;
	logic [31:0] hrdata, active_params;
	logic [1:0] set_in_use, line_in;
	int failures = 0;
	int comparisons = 0;
	logic [31:0] st = 32'h9b81;
	logic [31:0] q, d, pre;
	logic [31:0] slotv [4];
	logic [1:0] inv = 2'h0;
	logic s0 = 1'b0;
	logic cnt2 = 1'b0;

	always #12.5 hclk = ~hclk;

	line_addressed_set_selector line_addressed_set_selector_i (
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .line_in(line_in),
		.frame_trig(frame_trig), .frame_end(frame_end),
		.active_params(active_params), .set_in_use(set_in_use),
		.waiting_trig(waiting_trig), .frame_busy(frame_busy),
		.seq_running(seq_running)
	);

	line_driver line_driver_i (.hclk(hclk), .want(want), .line_in(line_in));

	function automatic logic [31:0] rnd();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return st;
	endfunction

	// Expected set address from line levels and the bench's own setup
	function automatic logic [1:0] ea(input logic [1:0] ln);
		logic b0;
		logic b1;
		b0 = ln[s0] ^ inv[s0];
		b1 = cnt2 ? 1'b0 : (ln[!s0] ^ inv[!s0]);
		return {b1, b0};
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	// One single AHB-Lite transfer; read data lands in q
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] v);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= set_sel_pkg::HSIZE_WORD;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= v;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic fire();
		@(posedge hclk) frame_trig <= 1'b1;
		@(posedge hclk) frame_trig <= 1'b0;
		@(negedge hclk);
	endtask

	task automatic done();
		@(posedge hclk) frame_end <= 1'b1;
		@(posedge hclk) frame_end <= 1'b0;
	endtask

	// Lines settle well before the trigger, then the addressed set loads
	task automatic shot(input logic [1:0] w);
		want <= w;
		repeat (10) @(posedge hclk);
		chk({31'h0, waiting_trig}, 32'h1);
		fire();
		chk(active_params, slotv[ea(w)]);
		chk({30'h0, set_in_use}, {30'h0, ea(w)});
		chk({31'h0, frame_busy}, 32'h1);
		done();
	endtask

	task automatic end_sim();
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		#500000;
		failures++;
		end_sim();
	end

	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		xfer(1'b0, set_sel_pkg::OFF_COUNT, 32'h0);
		chk(q, {29'h0, set_sel_pkg::COUNT_RST});
		xfer(1'b0, 8'h24, 32'h0);
		chk(q, 32'h0);
		xfer(1'b1, set_sel_pkg::OFF_COUNT, 32'h7);
		xfer(1'b0, set_sel_pkg::OFF_COUNT, 32'h0);
		chk(q, {29'h0, set_sel_pkg::COUNT_MAX});
		xfer(1'b1, set_sel_pkg::OFF_CTRL, 32'h4);
		xfer(1'b1, set_sel_pkg::OFF_PICK, 32'h0);
		xfer(1'b1, set_sel_pkg::OFF_LINE, 32'h0);
		xfer(1'b1, set_sel_pkg::OFF_PICK, 32'h1);
		xfer(1'b1, set_sel_pkg::OFF_LINE, 32'h1);
		// Fifth store lands on slot 0 again to prove overwrite
		for (int i = 0; i < 5; i++) begin
			d = rnd();
			slotv[i % 4] = d;
			xfer(1'b1, set_sel_pkg::OFF_ACTIVE, d);
			xfer(1'b1, set_sel_pkg::OFF_SLOT, i % 4);
			xfer(1'b1, set_sel_pkg::OFF_STORE, 32'h1);
		end
		pre = rnd();
		xfer(1'b1, set_sel_pkg::OFF_ACTIVE, pre);
		for (int k = 0; k < 2; k++) begin
			inv = k ? 2'h3 : 2'h0;
			xfer(1'b1, set_sel_pkg::OFF_CTRL, 32'h4);
			xfer(1'b1, set_sel_pkg::OFF_INVERT, {30'h0, inv});
			xfer(1'b1, set_sel_pkg::OFF_CTRL, 32'h5);
			for (int j = 0; j < 6; j++)
				shot(j < 4 ? j[1:0] : 2'(rnd()));
		end
		// Trigger lands while the synchroniser still sees the change;
		// waiting status lags a cycle, so it is too late to wait on
		want <= ~want;
		repeat (3) @(posedge hclk);
		frame_trig <= 1'b1;
		@(posedge hclk) frame_trig <= 1'b0;
		@(negedge hclk);
		chk({31'h0, frame_busy}, 32'h0);
		chk({31'h0, waiting_trig}, 32'h0);
		// Disable in mid-frame: frame ends first, then values restore
		want <= 2'h2;
		repeat (10) @(posedge hclk);
		fire();
		xfer(1'b1, set_sel_pkg::OFF_CTRL, 32'h4);
		chk(active_params, slotv[ea(2'h2)]);
		chk({31'h0, seq_running}, 32'h1);
		done();
		repeat (3) @(posedge hclk);
		chk(active_params, pre);
		chk({31'h0, seq_running}, 32'h0);
		xfer(1'b1, set_sel_pkg::OFF_COUNT, 32'h2);
		xfer(1'b0, set_sel_pkg::OFF_PICK, 32'h0);
		chk(q, 32'h0);
		xfer(1'b1, set_sel_pkg::OFF_LINE, 32'h1);
		s0 = 1'b1;
		cnt2 = 1'b1;
		xfer(1'b1, set_sel_pkg::OFF_CTRL, 32'h5);
		for (int j = 0; j < 4; j++)
			shot(j[1:0]);
		end_sim();
	end
endmodule // line_addressed_set_selector_test
